// ===== hw/smie_pkg.sv
package smie_pkg;

  // instruction classes presented by the decode stage
  typedef enum logic [3:0] {
    SMIE_OP_NOP  = 4'h0,
    SMIE_OP_BREAKPOINT_INSTR = 4'h1,
    SMIE_OP_CPS  = 4'h2,
    SMIE_OP_DMB  = 4'h3,
    SMIE_OP_DSB  = 4'h4,
    SMIE_OP_ISB  = 4'h5,
    SMIE_OP_MRS  = 4'h6,
    SMIE_OP_MSR  = 4'h7,
    SMIE_OP_SEV  = 4'h8
  } smie_op_t;

  // special register selector
  typedef enum logic [2:0] {
    SMIE_SR_APP_STATUS_PSR   = 3'h0,
    SMIE_SR_EXCEPTION_NUMBER_PSR   = 3'h1,
    SMIE_SR_EXEC_STATE_PSR   = 3'h2,
    SMIE_SR_PSR    = 3'h3,
    SMIE_SR_IMASK  = 3'h4,
    SMIE_SR_THR    = 3'h5,
    SMIE_SR_THRMAX = 3'h6,
    SMIE_SR_FMASK  = 3'h7
  } smie_sreg_t;

  // sequencer states, one-hot
  typedef enum logic [1:0] {
    SMIE_ST_IDLE  = 2'b01,
    SMIE_ST_DRAIN = 2'b10
  } smie_state_t;

  // decoded instruction as handed to the executor
  typedef struct packed {
    smie_op_t    op;
    logic [7:0]  imm;        // breakpoint immediate, never used
    logic [3:0]  opt;        // barrier option field
    logic        set_effect; // 1 set masks, 0 clear masks
    logic        flag_i;
    logic        flag_f;
    smie_sreg_t  sreg;
    logic        ns_suffix;
    logic [1:0]  psr_fields; // bit0 flags+q, bit1 ge
    logic [31:0] wdata;
    logic        cond_pass;
    logic        privileged;
    logic        secure;
  } smie_req_t;

  localparam logic [3:0]  SMIE_OPT_FULL  = 4'hF;
  localparam logic [31:0] SMIE_APP_STATUS_PSR_NZCVQ = 32'hF8000000;
  localparam logic [31:0] SMIE_APP_STATUS_PSR_GE    = 32'h000F0000;
  localparam int          SMIE_THR_W      = 8;

  // register map, byte addresses
  localparam logic [11:0] SMIE_ADDR_CTRL   = 12'h000;
  localparam logic [11:0] SMIE_ADDR_STATUS = 12'h004;
  localparam logic [11:0] SMIE_ADDR_MASKS  = 12'h008;
  localparam logic [11:0] SMIE_ADDR_THR    = 12'h00C;
  // control fields
  localparam int SMIE_CTRL_DBG_EN  = 0;
  localparam int SMIE_CTRL_EVT_CLR = 1;
  localparam logic SMIE_CTRL_RST   = 1'b0;

endpackage : smie_pkg

// ===== hw/smie_exec.sv
// Overview of operation
// RULE1: breakpoint halts into debug state when invasive debug is enabled.
// RULE2: breakpoint immediate has no effect on execution.
// RULE3: breakpoint executes even when its condition fails.
// RULE4: change-state sets or clears selected interrupt and fault masks.
// RULE5: unprivileged change-state leaves both masks unchanged.
// RULE6: memory order barrier orders all accesses for any option value.
// RULE7: accesses before memory order barrier complete before later ones.
// RULE8: memory order barrier never stalls non-memory instructions.
// RULE9: completion barrier covers all accesses for any option value.
// RULE10: completion barrier waits for earlier accesses; blocks later ones.
// RULE11: fetch sync barrier is full operation for any option value.
// RULE12: fetch sync barrier flushes the pipeline for refetch.
// RULE13: status reads return exec-state and exception-number as zero.
// RULE14: unbanked reads current bank; NS name reads NS or zero.
// RULE15: reading threshold-raise returns the threshold.
// RULE16: software never names stack pointer or pc as operand.
// RULE17: unprivileged special writes reach only the application status.
// RULE18: unprivileged status writes ignore unallocated and exec bits.
// RULE19: threshold-raise writes only nonzero lower or over-zero values.
// RULE20: unbanked writes current bank; NS name ignored from NS.
// RULE21: no-operation has no architectural effect.
// RULE22: send event signals all processors and sets event register.
// RULE23: unprivileged write to other register completes without fault.
//
// Our own choices: the address map and the APB register port.
module smie_exec (
  // clock and reset
  input  wire  logic              mclk,
  input  wire  logic              rst_n,
  // instruction stream
  input  wire  logic              instr_valid,
  output logic                    instr_ready,
  input  wire  smie_pkg::smie_req_t instr_req,
  output logic                    instr_done,
  output logic [31:0]             instr_rdata,
  // memory system
  input  wire  logic              mem_idle,
  output logic                    mem_hold,
  // pipeline, debug and events
  output logic                    pipe_flush,
  output logic                    debug_halt,
  output logic                    event_out,
  // secure bank mask state
  output logic                    cur_int_mask,
  output logic                    cur_fault_mask,
  output logic [7:0]              cur_threshold,
  // apb slave
  input  wire  logic              psel,
  input  wire  logic              penable,
  input  wire  logic              pwrite,
  input  wire  logic [11:0]       paddr,
  input  wire  logic [31:0]       pwdata,
  output logic [31:0]             prdata,
  output logic                    pready,
  output logic                    pslverr
);
  import smie_pkg::*;

  // bank index: 1 secure, 0 non-secure
  function automatic logic bank_of(input smie_req_t r);
    bank_of = r.secure & ~r.ns_suffix;
  endfunction : bank_of

  // access blocked when NS name used from non-secure state
  function automatic logic ns_blocked(input smie_req_t r);
    ns_blocked = r.ns_suffix & ~r.secure;
  endfunction : ns_blocked

  smie_state_t       state;
  smie_state_t       next_state;
  logic [1:0]        imask;
  logic [1:0]        fmask;
  logic [7:0]        thr [2];
  logic [31:0]       app_status_psr;
  logic              event_reg;
  logic              dbg_en;
  logic              accept;
  logic              execs;
  logic              bank;
  logic              blk;
  logic              is_breakpoint_instr;
  logic              is_cps;
  logic              is_dmb;
  logic              is_dsb;
  logic              is_isb;
  logic              is_mrs;
  logic              is_msr;
  logic              is_sev;
  logic              msr_ok;
  logic [7:0]        src8;
  logic [7:0]        thr_cur;
  logic              thr_max_ok;
  logic [31:0]       app_status_psr_wmask;
  logic [31:0]       next_rdata;
  logic              done_now;
  logic              apb_wr;
  logic              apb_rd;
  logic              addr_hit;
  logic [31:0]       apb_rmux;

  // request decode
  assign accept  = instr_valid & instr_ready;
  assign execs   = accept & instr_req.cond_pass;
  assign bank    = bank_of(instr_req);
  assign blk     = ns_blocked(instr_req);
  assign is_breakpoint_instr = accept & (instr_req.op == SMIE_OP_BREAKPOINT_INSTR); // RULE3
  assign is_cps  = execs & (instr_req.op == SMIE_OP_CPS);
  assign is_dmb  = execs & (instr_req.op == SMIE_OP_DMB);   // RULE6
  assign is_dsb  = execs & (instr_req.op == SMIE_OP_DSB);   // RULE9
  assign is_isb  = execs & (instr_req.op == SMIE_OP_ISB);   // RULE11
  assign is_mrs  = execs & (instr_req.op == SMIE_OP_MRS);
  assign is_msr  = execs & (instr_req.op == SMIE_OP_MSR);
  assign is_sev  = execs & (instr_req.op == SMIE_OP_SEV);

  // special write permission and threshold-raise test
  // RULE23: refused writes still complete through done_now
  assign msr_ok     = is_msr & ~blk & instr_req.privileged; // RULE17 RULE20
  assign src8       = instr_req.wdata[7:0];
  assign thr_cur    = thr[bank];
  assign thr_max_ok = (src8 != 8'h00) &&
                      ((thr_cur == 8'h00) || (src8 < thr_cur)); // RULE19
  assign app_status_psr_wmask = (instr_req.psr_fields[0] ? SMIE_APP_STATUS_PSR_NZCVQ : 32'h0) |
                      (instr_req.psr_fields[1] ? SMIE_APP_STATUS_PSR_GE    : 32'h0);

  // sequencer: completion barrier holds off everything after it
  assign instr_ready = (state == SMIE_ST_IDLE);             // RULE10
  always_comb begin
    next_state = state;
    case (state)
      SMIE_ST_IDLE:  if (is_dsb && !mem_idle) next_state = SMIE_ST_DRAIN;
      SMIE_ST_DRAIN: if (mem_idle) next_state = SMIE_ST_IDLE; // RULE10
      default:       next_state = SMIE_ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= SMIE_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // completion: one cycle after acceptance, or when the drain ends
  // a no-operation only completes, touching no state
  assign done_now = (accept & ~(is_dsb & ~mem_idle)) | // RULE21
                    ((state == SMIE_ST_DRAIN) & mem_idle);

  // special register read value
  always_comb begin
    next_rdata = 32'h0;
    if (!blk) begin                                         // RULE14
      case (instr_req.sreg)
        SMIE_SR_APP_STATUS_PSR:   next_rdata = app_status_psr;
        SMIE_SR_PSR:    next_rdata = app_status_psr;                  // RULE13
        SMIE_SR_IMASK:  next_rdata = {31'h0, imask[bank]};
        SMIE_SR_FMASK:  next_rdata = {31'h0, fmask[bank]};
        SMIE_SR_THR:    next_rdata = {24'h0, thr_cur};
        SMIE_SR_THRMAX: next_rdata = {24'h0, thr_cur};      // RULE15
        default:        next_rdata = 32'h0;                 // RULE13
      endcase
    end
  end

  // answer registers and one-cycle pulses
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      instr_done  <= 1'b0;
      instr_rdata <= 32'h0;
      pipe_flush  <= 1'b0;
      debug_halt  <= 1'b0;
      event_out   <= 1'b0;
    end else begin
      instr_done  <= done_now;
      instr_rdata <= is_mrs ? next_rdata : 32'h0;
      pipe_flush  <= is_isb;                                // RULE12
      debug_halt  <= is_breakpoint_instr & dbg_en;                      // RULE1 RULE2
      event_out   <= is_sev;                                // RULE22
    end
  end

  // memory order barrier: hold later accesses until earlier ones end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mem_hold <= 1'b0;
    end else if (is_dmb) begin
      mem_hold <= 1'b1;                                     // RULE7
    end else if (mem_idle) begin
      mem_hold <= 1'b0;
    end
  end

  // banked mask and threshold registers
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_bank
      logic sel;
      assign sel = (bank == 1'(g));
      always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          imask[g] <= 1'b0;
          fmask[g] <= 1'b0;
          thr[g]   <= 8'h00;
        end else if (sel) begin
          if (is_cps && instr_req.privileged) begin         // RULE5
            if (instr_req.flag_i) imask[g] <= instr_req.set_effect; // RULE4
            if (instr_req.flag_f) fmask[g] <= instr_req.set_effect; // RULE4
          end
          if (msr_ok) begin
            case (instr_req.sreg)
              SMIE_SR_IMASK:  imask[g] <= instr_req.wdata[0];
              SMIE_SR_FMASK:  fmask[g] <= instr_req.wdata[0];
              SMIE_SR_THR:    thr[g]   <= src8;
              SMIE_SR_THRMAX: if (thr_max_ok) thr[g] <= src8; // RULE19
              default:        ;
            endcase
          end
        end
      end
    end
  endgenerate

  // application status: only allocated flag bits are ever stored
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      app_status_psr <= 32'h0;
    end else if (is_msr && !blk && ((instr_req.sreg == SMIE_SR_APP_STATUS_PSR) ||
                 (instr_req.sreg == SMIE_SR_PSR))) begin    // RULE17
      app_status_psr <= (app_status_psr & ~app_status_psr_wmask) |
              (instr_req.wdata & app_status_psr_wmask);               // RULE18
    end
  end

  // event register: a send wins over a software clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      event_reg <= 1'b0;
    end else if (is_sev) begin
      event_reg <= 1'b1;                                    // RULE22
    end else if (apb_wr && paddr == SMIE_ADDR_CTRL &&
                 pwdata[SMIE_CTRL_EVT_CLR]) begin
      event_reg <= 1'b0;
    end
  end

  // secure bank view of the masks, whatever the current security state
  assign cur_int_mask   = imask[1];
  assign cur_fault_mask = fmask[1];
  assign cur_threshold  = thr[1];

  // apb slave: zero wait states, error on unmapped address
  assign apb_wr   = psel & penable & pwrite;
  assign apb_rd   = psel & penable & ~pwrite;
  assign pready   = 1'b1;
  assign addr_hit = (paddr == SMIE_ADDR_CTRL) ||
                    (paddr == SMIE_ADDR_STATUS) ||
                    (paddr == SMIE_ADDR_MASKS) ||
                    (paddr == SMIE_ADDR_THR);
  assign pslverr  = psel & penable & ~addr_hit;
  assign apb_rmux =
    (paddr == SMIE_ADDR_CTRL)   ? {31'h0, dbg_en} :
    (paddr == SMIE_ADDR_STATUS) ? {29'h0, mem_hold,
                                   state == SMIE_ST_DRAIN, event_reg} :
    (paddr == SMIE_ADDR_MASKS)  ? {28'h0, fmask, imask} :
    (paddr == SMIE_ADDR_THR)    ? {16'h0, thr[1], thr[0]} : 32'h0;

  // control register and read data
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      dbg_en <= SMIE_CTRL_RST;
      prdata <= 32'h0;
    end else begin
      if (apb_wr && paddr == SMIE_ADDR_CTRL) dbg_en <= pwdata[SMIE_CTRL_DBG_EN];
      prdata <= (psel & ~penable & ~pwrite) ? apb_rmux : prdata;
    end
  end

  // checks
  property p_breakpoint_instr_halt;
    @(posedge mclk) disable iff (!rst_n)
    (is_breakpoint_instr && dbg_en) |=> debug_halt;
  endproperty
  a_breakpoint_instr_halt: assert property (p_breakpoint_instr_halt) // RULE1
    else $error("breakpoint did not halt");

  property p_breakpoint_instr_cond;
    @(posedge mclk) disable iff (!rst_n)
    (accept && instr_req.op == SMIE_OP_BREAKPOINT_INSTR && !instr_req.cond_pass &&
     dbg_en) |=> debug_halt;
  endproperty
  a_breakpoint_instr_cond: assert property (p_breakpoint_instr_cond) // RULE3
    else $error("failed-condition breakpoint skipped");

  property p_cps_unpriv;
    @(posedge mclk) disable iff (!rst_n)
    (is_cps && !instr_req.privileged) |=> ($stable(imask) && $stable(fmask));
  endproperty
  a_cps_unpriv: assert property (p_cps_unpriv) // RULE5
    else $error("unprivileged change-state altered masks");

  property p_dmb_nostall;
    @(posedge mclk) disable iff (!rst_n)
    is_dmb |=> (instr_ready && mem_hold);
  endproperty
  a_dmb_nostall: assert property (p_dmb_nostall) // RULE8
    else $error("memory order barrier stalled stream");

  property p_dsb_block;
    @(posedge mclk) disable iff (!rst_n)
    (is_dsb && !mem_idle) |=> (!instr_ready until_with mem_idle);
  endproperty
  a_dsb_block: assert property (p_dsb_block) // RULE10
    else $error("completion barrier released early");

  property p_isb_flush;
    @(posedge mclk) disable iff (!rst_n)
    is_isb |=> (pipe_flush && instr_done) ##1
               (!pipe_flush || $past(is_isb));
  endproperty
  a_isb_flush: assert property (p_isb_flush) // RULE12
    else $error("fetch barrier did not flush once");

  property p_mrs_zero;
    @(posedge mclk) disable iff (!rst_n)
    (is_mrs && (instr_req.sreg == SMIE_SR_EXCEPTION_NUMBER_PSR ||
                instr_req.sreg == SMIE_SR_EXEC_STATE_PSR || blk))
    |=> (instr_rdata == 32'h0);
  endproperty
  a_mrs_zero: assert property (p_mrs_zero) // RULE13
    else $error("status read not zero");

  property p_thrmax;
    @(posedge mclk) disable iff (!rst_n)
    (is_msr && instr_req.sreg == SMIE_SR_THRMAX && src8 == 8'h00)
    |=> $stable(thr[1]) && $stable(thr[0]);
  endproperty
  a_thrmax: assert property (p_thrmax) // RULE19
    else $error("zero threshold-raise changed threshold");

  property p_unpriv_msr;
    @(posedge mclk) disable iff (!rst_n)
    (is_msr && !instr_req.privileged && instr_req.sreg != SMIE_SR_APP_STATUS_PSR)
    |=> ($stable(imask) && $stable(fmask) && instr_done);
  endproperty
  a_unpriv_msr: assert property (p_unpriv_msr) // RULE23
    else $error("unprivileged write changed a mask");

  property p_sev;
    @(posedge mclk) disable iff (!rst_n)
    is_sev |=> (event_out && event_reg);
  endproperty
  a_sev: assert property (p_sev) // RULE22
    else $error("send event missing");

  c_dsb_drain: cover property (@(posedge mclk) disable iff (!rst_n)
    state == SMIE_ST_DRAIN ##1 state == SMIE_ST_IDLE);
  c_thr_raise: cover property (@(posedge mclk) disable iff (!rst_n)
    is_msr && instr_req.sreg == SMIE_SR_THRMAX && thr_max_ok);
  c_breakpoint_instr: cover property (@(posedge mclk) disable iff (!rst_n) debug_halt);

endmodule : smie_exec

// ===== sim/system_misc_instr_exec_tb.sv
module system_misc_instr_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import smie_pkg::*;

  // one table row: request and what it should leave behind
  typedef struct packed {
    smie_req_t   rq;
    logic [2:0]  pul;  // halt, event, flush
    logic [31:0] rd;
    logic        im;
    logic        fm;
    logic [7:0]  thr;
  } smie_tb_row_t;

  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        instr_valid = 1'b0;
  smie_req_t   instr_req = '0;
  logic        mem_idle = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic        instr_ready, instr_done, mem_hold, pipe_flush;
  logic        debug_halt, event_out, cur_int_mask, cur_fault_mask;
  logic        pready, pslverr;
  logic [7:0]  cur_threshold;
  logic [31:0] instr_rdata, prdata, rd;
  logic        er;
  int          miscompares = 0;
  int          checks_done = 0;
  int          cyc = 0;
  int          n;
  smie_tb_row_t rows[$];

  smie_exec smie_exec_inst (
    .mclk(mclk), .rst_n(rst_n), .instr_valid(instr_valid),
    .instr_ready(instr_ready), .instr_req(instr_req),
    .instr_done(instr_done), .instr_rdata(instr_rdata),
    .mem_idle(mem_idle), .mem_hold(mem_hold), .pipe_flush(pipe_flush),
    .debug_halt(debug_halt), .event_out(event_out),
    .cur_int_mask(cur_int_mask), .cur_fault_mask(cur_fault_mask),
    .cur_threshold(cur_threshold), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr)
  );

  // clock and hang guard
  always #4 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end

  task automatic test_done();
    if (miscompares == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  // builds a request; low bits of wd carry cps flags and barrier option
  // no request names sp or pc as its general operand
  function automatic smie_req_t mk(smie_op_t op, smie_sreg_t sr,
      logic [31:0] wd, logic pr, logic sc, logic ns);
    smie_req_t r;
    r = '0;
    r.op = op;
    r.imm = 8'hAB;
    r.opt = wd[3:0];
    r.set_effect = wd[0];
    r.flag_i = wd[1];
    r.flag_f = wd[2];
    r.sreg = sr;
    r.ns_suffix = ns;
    r.psr_fields = 2'b11;
    r.wdata = wd;
    r.cond_pass = (op != SMIE_OP_BREAKPOINT_INSTR);
    r.privileged = pr;
    r.secure = sc;
    return r;
  endfunction : mk

  task automatic add(smie_op_t op, smie_sreg_t sr, logic [31:0] wd,
      logic pr, logic sc, logic ns, logic [2:0] pul, logic [31:0] erd,
      logic im, logic fm, logic [7:0] thr);
    rows.push_back({mk(op, sr, wd, pr, sc, ns), pul, erd, im, fm, thr});
  endtask : add

  // hands one request over and returns just after the taking edge
  task automatic send(input smie_req_t r);
    @(posedge mclk);
    instr_valid <= 1'b1;
    instr_req   <= r;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (instr_ready !== 1'b1 && n < 100);
    instr_valid <= 1'b0;
    #1;
  endtask : send

  // apb master: setup, access, sample at the pready edge
  task automatic apb(input logic wr, input logic [11:0] a,
      input logic [31:0] wd, output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    chk({instr_ready, instr_done, cur_int_mask, cur_threshold, pready},
        {3'b100, 8'h00, 1'b1});
    rst_n <= 1'b1;
    apb(1'b0, SMIE_ADDR_CTRL, 32'h0, rd, er);
    chk(rd, 32'h0);
    apb(1'b1, SMIE_ADDR_CTRL, 32'h1, rd, er);
    add(SMIE_OP_BREAKPOINT_INSTR, SMIE_SR_APP_STATUS_PSR, 32'h0, 1, 1, 0, 3'b100, 0, 0, 0, 0);
    add(SMIE_OP_CPS, SMIE_SR_APP_STATUS_PSR, 32'h3, 1, 1, 0, 3'b000, 0, 1, 0, 0);
    add(SMIE_OP_CPS, SMIE_SR_APP_STATUS_PSR, 32'h5, 1, 1, 0, 3'b000, 0, 1, 1, 0);
    add(SMIE_OP_CPS, SMIE_SR_APP_STATUS_PSR, 32'h6, 0, 1, 0, 3'b000, 0, 1, 1, 0);
    add(SMIE_OP_CPS, SMIE_SR_APP_STATUS_PSR, 32'h6, 1, 1, 0, 3'b000, 0, 0, 0, 0);
    add(SMIE_OP_DMB, SMIE_SR_APP_STATUS_PSR, 32'h0, 1, 1, 0, 3'b000, 0, 0, 0, 0);
    add(SMIE_OP_ISB, SMIE_SR_APP_STATUS_PSR, 32'h3, 1, 1, 0, 3'b001, 0, 0, 0, 0);
    add(SMIE_OP_ISB, SMIE_SR_APP_STATUS_PSR, 32'hF, 1, 1, 0, 3'b001, 0, 0, 0, 0);
    add(SMIE_OP_SEV, SMIE_SR_APP_STATUS_PSR, 32'h0, 1, 1, 0, 3'b010, 0, 0, 0, 0);
    add(SMIE_OP_MSR, SMIE_SR_THRMAX, 32'h40, 1, 1, 0, 0, 0, 0, 0, 8'h40);
    add(SMIE_OP_MSR, SMIE_SR_THRMAX, 32'h00, 1, 1, 0, 0, 0, 0, 0, 8'h40);
    add(SMIE_OP_MSR, SMIE_SR_THRMAX, 32'h60, 1, 1, 0, 0, 0, 0, 0, 8'h40);
    add(SMIE_OP_MSR, SMIE_SR_THRMAX, 32'h20, 1, 1, 0, 0, 0, 0, 0, 8'h20);
    add(SMIE_OP_MRS, SMIE_SR_THRMAX, 32'h0, 1, 1, 0, 0, 32'h20, 0, 0, 8'h20);
    add(SMIE_OP_MSR, SMIE_SR_THR, 32'h80, 0, 1, 0, 0, 0, 0, 0, 8'h20);
    add(SMIE_OP_MSR, SMIE_SR_IMASK, 32'h1, 0, 1, 0, 0, 0, 0, 0, 8'h20);
    add(SMIE_OP_MSR, SMIE_SR_IMASK, 32'h1, 1, 0, 1, 0, 0, 0, 0, 8'h20);
    add(SMIE_OP_MRS, SMIE_SR_IMASK, 32'h0, 1, 0, 0, 0, 0, 0, 0, 8'h20);
    add(SMIE_OP_MSR, SMIE_SR_IMASK, 32'h1, 1, 1, 1, 0, 0, 0, 0, 8'h20);
    add(SMIE_OP_MRS, SMIE_SR_IMASK, 32'h0, 1, 1, 1, 0, 32'h1, 0, 0, 8'h20);
    add(SMIE_OP_MRS, SMIE_SR_IMASK, 32'h0, 1, 0, 1, 0, 0, 0, 0, 8'h20);
    add(SMIE_OP_MRS, SMIE_SR_IMASK, 32'h0, 1, 0, 0, 0, 32'h1, 0, 0, 8'h20);
    add(SMIE_OP_MSR, SMIE_SR_PSR, 32'hFFFFFFFF, 0, 1, 0, 0, 0, 0, 0, 8'h20);
    add(SMIE_OP_MRS, SMIE_SR_APP_STATUS_PSR, 32'h0, 0, 1, 0, 0,
        SMIE_APP_STATUS_PSR_NZCVQ | SMIE_APP_STATUS_PSR_GE, 0, 0, 8'h20);
    add(SMIE_OP_MRS, SMIE_SR_PSR, 32'h0, 1, 1, 0, 0,
        SMIE_APP_STATUS_PSR_NZCVQ | SMIE_APP_STATUS_PSR_GE, 0, 0, 8'h20);
    add(SMIE_OP_MRS, SMIE_SR_EXCEPTION_NUMBER_PSR, 32'h0, 1, 1, 0, 0, 0, 0, 0, 8'h20);
    add(SMIE_OP_MRS, SMIE_SR_EXEC_STATE_PSR, 32'h0, 1, 1, 0, 0, 0, 0, 0, 8'h20);
    add(SMIE_OP_NOP, SMIE_SR_THR, 32'h5, 1, 1, 0, 0, 0, 0, 0, 8'h20);
    // table: breakpoint_instr, cps, barriers, sev, special moves, nop
    foreach (rows[i]) begin
      send(rows[i].rq);
      chk({instr_done, debug_halt, event_out, pipe_flush},
          {1'b1, rows[i].pul});
      chk(instr_rdata, rows[i].rd);
      chk({cur_int_mask, cur_fault_mask, cur_threshold},
          {rows[i].im, rows[i].fm, rows[i].thr});
    end
    // bank state seen through the registers
    apb(1'b0, SMIE_ADDR_MASKS, 32'h0, rd, er);
    chk(rd, 32'h1);
    apb(1'b0, SMIE_ADDR_THR, 32'h0, rd, er);
    chk(rd, 32'h2000);
    // event register, clear by control write, unmapped address
    apb(1'b0, SMIE_ADDR_STATUS, 32'h0, rd, er);
    chk(rd[0], 1'b1);
    apb(1'b1, SMIE_ADDR_CTRL, 32'h2, rd, er);
    apb(1'b0, SMIE_ADDR_STATUS, 32'h0, rd, er);
    chk(rd[0], 1'b0);
    apb(1'b0, 12'h010, 32'h0, rd, er);
    chk({er, rd}, {1'b1, 32'h0});
    // breakpoint with debug disabled
    send(mk(SMIE_OP_BREAKPOINT_INSTR, SMIE_SR_APP_STATUS_PSR, 32'h0, 1, 1, 0));
    chk({instr_done, debug_halt}, 2'b10);
    // memory barrier with traffic outstanding: no stall, later held
    @(posedge mclk);
    mem_idle <= 1'b0;
    send(mk(SMIE_OP_DMB, SMIE_SR_APP_STATUS_PSR, 32'h0, 1, 1, 0));
    chk({instr_done, mem_hold}, 2'b11);
    mem_idle <= 1'b1;
    repeat (3) @(posedge mclk);
    // completion barrier drains before anything else runs
    mem_idle <= 1'b0;
    send(mk(SMIE_OP_DSB, SMIE_SR_APP_STATUS_PSR, 32'h5, 1, 1, 0));
    repeat (4) begin
      chk({instr_done, instr_ready}, 2'b00);
      @(posedge mclk);
      #1;
    end
    mem_idle <= 1'b1;
    n = 0;
    while (instr_done !== 1'b1 && n < 20) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(instr_done, 1'b1);
    send(mk(SMIE_OP_SEV, SMIE_SR_APP_STATUS_PSR, 32'h0, 1, 1, 0));
    chk({instr_done, event_out}, 2'b11);
    test_done();
  end
endmodule : system_misc_instr_exec_tb
